/* design/readout_pkg.sv */
// shared constants, types and register map of the quad converter readout block
package readout_pkg;

  // ---------------------------------------------------------------------------
  // readout geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_CH   = 4;
  localparam int unsigned RESULT_W = 16;
  localparam logic [3:0]  MSB_POS  = 4'hF;
  localparam logic [3:0]  LSB_POS  = 4'h0;

  // ---------------------------------------------------------------------------
  // power state strobe counts
  // ---------------------------------------------------------------------------
  localparam logic [2:0] NAP_COUNT   = 3'h2;
  localparam logic [2:0] SLEEP_COUNT = 3'h4;
  localparam logic [2:0] WAKE_COUNT  = 3'h5;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  RESULT0_OFF  = 8'h00;
  localparam logic [7:0]  RESULT1_OFF  = 8'h04;
  localparam logic [7:0]  RESULT2_OFF  = 8'h08;
  localparam logic [7:0]  RESULT3_OFF  = 8'h0C;
  localparam logic [7:0]  STATUS_OFF   = 8'h10;
  localparam logic [2:0]  IDX_STATUS   = 3'h4;
  localparam logic [2:0]  IDX_NONE     = 3'h7;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

  // status fields
  localparam int unsigned ST_STATE_LSB   = 0;
  localparam int unsigned ST_COUNT_LSB   = 2;
  localparam int unsigned ST_DIFF_BIT    = 5;
  localparam int unsigned ST_DDR_BIT     = 6;
  localparam int unsigned ST_READOUT_BIT = 7;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {PWR_OP, PWR_NAP, PWR_SLEEP} power_state_t;

  typedef logic [NUM_CH-1:0][RESULT_W-1:0] result_bank_t;

  typedef struct packed {
    logic strobe_n;
    logic sck;
    logic diff;
    logic ddr;
  } pin_in_t;

  // the host idles the strobe low; a high reset value would fake a strobe fall after reset
  localparam pin_in_t PIN_RESET = '{strobe_n: 1'h0, sck: 1'h0, diff: 1'h0, ddr: 1'h0};

endpackage : readout_pkg

/* design/pin_sync.sv */
// two-stage synchroniser for the pins that arrive from the host
`timescale 1ns/1ns
module pin_sync
(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // pins and synchronised copy
  input  wire readout_pkg::pin_in_t pin_raw,
  output readout_pkg::pin_in_t      pin_sync_q
);

  readout_pkg::pin_in_t meta_q;

  // ---------------------------------------------------------------------------
  // the first stage feeds the second and nothing else
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q     <= readout_pkg::PIN_RESET;
      pin_sync_q <= readout_pkg::PIN_RESET;
    end
    else
    begin
      meta_q     <= pin_raw;
      pin_sync_q <= meta_q;
    end
  end

endmodule : pin_sync

/* design/lane_shifter.sv */
// one serial lane: walks the channel results circularly, msb first
`timescale 1ns/1ns
module lane_shifter
(
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // control
  input  wire logic                      load,
  input  wire logic                      advance,
  input  wire logic [1:0]                first_ch,
  input  wire readout_pkg::result_bank_t bank,
  // serial bit
  output logic                           bit_q
);

  logic [1:0] ch_q;
  logic [3:0] pos_q;
  logic [1:0] ch_d;
  logic [3:0] pos_d;

  // ---------------------------------------------------------------------------
  // slot walk
  // ---------------------------------------------------------------------------
  always_comb
  begin
    ch_d  = ch_q;
    pos_d = pos_q;
    if (load)
    begin
      ch_d  = first_ch;
      pos_d = readout_pkg::MSB_POS;
    end
    else if (advance)
    begin
      if (pos_q == readout_pkg::LSB_POS)
      begin
        ch_d  = ch_q + 2'h1;
        pos_d = readout_pkg::MSB_POS;
      end
      else
      begin
        pos_d = pos_q - 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch_q  <= 2'h0;
      pos_q <= readout_pkg::MSB_POS;
      bit_q <= 1'h0;
    end
    else
    begin
      ch_q  <= ch_d;
      pos_q <= pos_d;
      if (load || advance)
        bit_q <= bank[ch_d][pos_d];
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_bit_step;
    @(posedge pclk) disable iff (!presetn)
    (advance && !load && pos_q != readout_pkg::LSB_POS) |=> (pos_q == $past(pos_q) - 4'h1) && $stable(ch_q);
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("lane bit slot did not step down");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    (advance && !load && pos_q == readout_pkg::LSB_POS) |=> (pos_q == readout_pkg::MSB_POS) && (ch_q == $past(ch_q) + 2'h1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("lane did not move to next channel msb");

endmodule : lane_shifter

/* design/quad_readout.sv */
// serial readout and nap/sleep power control of the quad converter, apb register view
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module quad_readout
(
  // clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // apb slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [readout_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // host pins
  input  wire logic                             conversion_strobe_n,
  input  wire logic                             shift_clock,
  input  wire logic                             io_mode_diff,
  input  wire logic                             data_rate_select,
  // single-ended lanes
  output logic                                  cmos_lane_one,
  output logic                                  cmos_lane_two,
  output logic                                  cmos_lane_three,
  output logic                                  cmos_lane_four,
  // differential lanes
  output logic                                  diff_lane_a,
  output logic                                  diff_lane_b,
  output logic                                  diff_lane_c,
  output logic                                  diff_lane_d,
  // echo clock and power state
  output logic                                  echo_shift_clock,
  output readout_pkg::power_state_t             power_mode
);

  // ---------------------------------------------------------------------------
  // pin synchronisation and edge detection
  // ---------------------------------------------------------------------------
  readout_pkg::pin_in_t pin_raw;
  readout_pkg::pin_in_t pin_s;
  logic                 sck_prev_q;
  logic                 strobe_prev_q;
  logic                 sck_rise;
  logic                 sck_fall;
  logic                 sck_edge;
  logic                 strobe_rise;
  logic                 strobe_fall;

  assign pin_raw = '{strobe_n: conversion_strobe_n, sck: shift_clock,
                     diff: io_mode_diff, ddr: data_rate_select};

  pin_sync u_sync
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_raw    (pin_raw),
    .pin_sync_q (pin_s)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_prev_q    <= 1'h0;
      strobe_prev_q <= 1'h0;
    end
    else
    begin
      sck_prev_q    <= pin_s.sck;
      strobe_prev_q <= pin_s.strobe_n;
    end
  end

  assign sck_rise    = pin_s.sck && !sck_prev_q;
  assign sck_fall    = !pin_s.sck && sck_prev_q;
  assign sck_edge    = sck_rise || sck_fall;
  assign strobe_rise = pin_s.strobe_n && !strobe_prev_q;
  assign strobe_fall = !pin_s.strobe_n && strobe_prev_q;

  // ---------------------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------------------
  readout_pkg::power_state_t state_q;
  readout_pkg::power_state_t state_d;
  logic [2:0]                cnt_q;
  logic [2:0]                cnt_d;
  logic                      sck_wake;
  logic                      sck_clear;

  // a differential sleeper ignores the shift clock; only the fifth strobe wakes it
  assign sck_wake  = sck_rise && (state_q == readout_pkg::PWR_NAP ||
                                  (state_q == readout_pkg::PWR_SLEEP && !pin_s.diff));
  assign sck_clear = sck_edge && (state_q != readout_pkg::PWR_SLEEP || !pin_s.diff);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (sck_clear)
      cnt_d = 3'h0;
    if (sck_wake)
      state_d = readout_pkg::PWR_OP;
    if (strobe_rise)
    begin
      cnt_d = cnt_d + 3'h1;
      case (state_d)
        readout_pkg::PWR_OP:
          if (cnt_d == readout_pkg::NAP_COUNT)
            state_d = readout_pkg::PWR_NAP;
        readout_pkg::PWR_NAP:
          if (cnt_d == readout_pkg::SLEEP_COUNT)
            state_d = readout_pkg::PWR_SLEEP;
        readout_pkg::PWR_SLEEP:
          if (cnt_d == readout_pkg::WAKE_COUNT)
          begin
            state_d = readout_pkg::PWR_OP;
            cnt_d   = 3'h0;
          end
        default:
          state_d = readout_pkg::PWR_OP;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= readout_pkg::PWR_OP;
      cnt_q      <= 3'h0;
      power_mode <= readout_pkg::PWR_OP;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      power_mode <= state_d;
    end
  end

  // ---------------------------------------------------------------------------
  // sampling and readout sequencing
  // ---------------------------------------------------------------------------
  readout_pkg::result_bank_t result_q;
  readout_pkg::result_bank_t sample_q;
  logic                      readout_q;
  logic                      advance;
  logic [3:0]                lane_bit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_q  <= '0;
      readout_q <= 1'h0;
    end
    else
    begin
      if (strobe_rise)
        sample_q <= result_q;
      if (state_q != readout_pkg::PWR_OP)
        readout_q <= 1'h0;
      else if (strobe_fall)
        readout_q <= 1'h1;
    end
  end

  // ddr shifts on both edges, so the host needs half the shift rate
  assign advance = readout_q && (state_q == readout_pkg::PWR_OP) &&
                   (pin_s.ddr ? sck_edge : sck_fall);

  for (genvar g = 0; g < readout_pkg::NUM_CH; g++)
  begin : g_lane
    lane_shifter u_lane
    (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (strobe_fall && state_q == readout_pkg::PWR_OP),
      .advance  (advance),
      .first_ch (2'(g)),
      .bank     (sample_q),
      .bit_q    (lane_bit[g])
    );
  end

  // ---------------------------------------------------------------------------
  // pin drivers: one extra stage keeps echo and data aligned
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmos_lane_one    <= 1'h0;
      cmos_lane_two    <= 1'h0;
      cmos_lane_three  <= 1'h0;
      cmos_lane_four   <= 1'h0;
      diff_lane_a      <= 1'h0;
      diff_lane_b      <= 1'h0;
      diff_lane_c      <= 1'h0;
      diff_lane_d      <= 1'h0;
      echo_shift_clock <= 1'h0;
    end
    else
    begin
      cmos_lane_one    <= lane_bit[0] && !pin_s.diff;
      cmos_lane_two    <= lane_bit[1] && !pin_s.diff;
      cmos_lane_three  <= lane_bit[2] && !pin_s.diff;
      cmos_lane_four   <= lane_bit[3] && !pin_s.diff;
      diff_lane_a      <= lane_bit[0] && pin_s.diff;
      diff_lane_b      <= lane_bit[1] && pin_s.diff;
      diff_lane_c      <= lane_bit[2] && pin_s.diff;
      diff_lane_d      <= lane_bit[3] && pin_s.diff;
      echo_shift_clock <= sck_prev_q;
    end
  end

  // ---------------------------------------------------------------------------
  // apb register file, one wait state on every access
  // ---------------------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [readout_pkg::ADDR_W-1:0] addr);
    case (addr)
      readout_pkg::RESULT0_OFF: reg_index = 3'h0;
      readout_pkg::RESULT1_OFF: reg_index = 3'h1;
      readout_pkg::RESULT2_OFF: reg_index = 3'h2;
      readout_pkg::RESULT3_OFF: reg_index = 3'h3;
      readout_pkg::STATUS_OFF:  reg_index = readout_pkg::IDX_STATUS;
      default:                  reg_index = readout_pkg::IDX_NONE;
    endcase
  endfunction : reg_index

  logic [2:0]  idx;
  logic        access;
  logic        bad;
  logic [31:0] status_word;
  logic [31:0] read_word;

  assign idx    = reg_index(paddr);
  assign access = psel && penable && !pready;
  assign bad    = (idx == readout_pkg::IDX_NONE) || (pwrite && idx == readout_pkg::IDX_STATUS);

  always_comb
  begin
    status_word                              = readout_pkg::RDATA_RESET;
    status_word[readout_pkg::ST_STATE_LSB+:2] = state_q;
    status_word[readout_pkg::ST_COUNT_LSB+:3] = cnt_q;
    status_word[readout_pkg::ST_DIFF_BIT]     = pin_s.diff;
    status_word[readout_pkg::ST_DDR_BIT]      = pin_s.ddr;
    status_word[readout_pkg::ST_READOUT_BIT]  = readout_q;
    if (idx == readout_pkg::IDX_STATUS)
      read_word = status_word;
    else if (idx < readout_pkg::IDX_STATUS)
      read_word = {16'h0000, result_q[idx[1:0]]};
    else
      read_word = readout_pkg::RDATA_RESET;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= readout_pkg::RDATA_RESET;
    end
    else
    begin
      pready <= access;
      if (access)
      begin
        pslverr <= bad;
        prdata  <= pwrite ? readout_pkg::RDATA_RESET : read_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_q <= {readout_pkg::NUM_CH{readout_pkg::RESULT_RESET}};
    else if (psel && penable && pready && pwrite && idx < readout_pkg::IDX_STATUS)
      result_q[idx[1:0]] <= pwdata[15:0];
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence s_quiet_strobe(logic [2:0] n);
    strobe_rise && !sck_edge && cnt_q == n;
  endsequence

  property p_nap_entry;
    @(posedge pclk) disable iff (!presetn)
    (state_q == readout_pkg::PWR_OP) ##0 s_quiet_strobe(3'h1) |=> state_q == readout_pkg::PWR_NAP;
  endproperty
  a_nap_entry: assert property (p_nap_entry) else $error("second quiet strobe did not enter nap");

  property p_nap_wake;
    @(posedge pclk) disable iff (!presetn)
    (state_q == readout_pkg::PWR_NAP && sck_rise) |=> state_q == readout_pkg::PWR_OP;
  endproperty
  a_nap_wake: assert property (p_nap_wake) else $error("shift rise did not leave nap");

  property p_sleep_entry;
    @(posedge pclk) disable iff (!presetn)
    (state_q == readout_pkg::PWR_NAP) ##0 s_quiet_strobe(3'h3) |=> state_q == readout_pkg::PWR_SLEEP;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("two strobes in nap did not sleep");

  property p_cmos_wake;
    @(posedge pclk) disable iff (!presetn)
    (state_q == readout_pkg::PWR_SLEEP && sck_rise && !pin_s.diff) |=> state_q == readout_pkg::PWR_OP;
  endproperty
  a_cmos_wake: assert property (p_cmos_wake) else $error("shift rise did not wake single-ended sleep");

  property p_fifth_wake;
    @(posedge pclk) disable iff (!presetn)
    (state_q == readout_pkg::PWR_SLEEP && !sck_wake) ##0 s_quiet_strobe(3'h4)
      |=> (state_q == readout_pkg::PWR_OP && cnt_q == 3'h0);
  endproperty
  a_fifth_wake: assert property (p_fifth_wake) else $error("fifth strobe did not wake");

  property p_keep_awake;
    @(posedge pclk) disable iff (!presetn)
    (sck_edge && !strobe_rise && state_q != readout_pkg::PWR_SLEEP) |=> cnt_q == 3'h0;
  endproperty
  a_keep_awake: assert property (p_keep_awake) else $error("shift edge did not clear strobe count");

  property p_sdr_hold;
    @(posedge pclk) disable iff (!presetn)
    (!pin_s.ddr && sck_rise && !strobe_fall && $stable(pin_s.diff)) |=> ##1 $stable(lane_bit);
  endproperty
  a_sdr_hold: assert property (p_sdr_hold) else $error("sdr lane moved on rising shift edge");

  property p_sdr_on_echo_fall;
    @(posedge pclk) disable iff (!presetn)
    (!pin_s.ddr && !pin_s.diff && $past(pin_s.diff, 2) == $past(pin_s.diff) && $past(readout_q, 2)
      && !$past(strobe_fall, 2) && $changed(cmos_lane_one)) |-> $fell(echo_shift_clock);
  endproperty
  a_sdr_on_echo_fall: assert property (p_sdr_on_echo_fall) else $error("sdr data not on echo fall");

  property p_msb_first;
    @(posedge pclk) disable iff (!presetn)
    (strobe_fall && state_q == readout_pkg::PWR_OP && $stable(pin_s.diff))
      |=> ##1 (cmos_lane_one == (sample_q[0][15] && !pin_s.diff)) && (diff_lane_d == (sample_q[3][15] && pin_s.diff));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("lane did not present first msb");

  property p_idle_side;
    @(posedge pclk) disable iff (!presetn)
    pin_s.diff |=> !cmos_lane_one && !cmos_lane_two && !cmos_lane_three && !cmos_lane_four;
  endproperty
  a_idle_side: assert property (p_idle_side) else $error("single-ended lane active in differential mode");

endmodule : quad_readout

/* dv/host_link.sv */
// host-side receiver model: drives strobe and shift clock, captures the lanes
`timescale 1ns/1ns
module host_link
(
  // clock
  input  wire logic       pclk,
  // static mode pins
  input  wire logic       io_mode_diff,
  input  wire logic       data_rate_select,
  // lanes and echo from the device
  input  wire logic [3:0] cmos_lanes,
  input  wire logic [3:0] diff_lanes,
  input  wire logic       echo_shift_clock,
  // host pins
  output logic            conversion_strobe_n,
  output logic            shift_clock
);
  logic [63:0] cap [4];
  logic [3:0]  lane_p;
  logic        echo_p;
  wire  [3:0]  lane = io_mode_diff ? diff_lanes : cmos_lanes;
  // idle low so the first pulse gives a real rising edge
  initial
  begin
    conversion_strobe_n = 1'b0;
    shift_clock = 1'b0;
  end
  // sdr: stable bit on echo rise; ddr: echo and data move together, so take the bit before the edge
  always @(posedge pclk)
  begin
    if (echo_shift_clock != echo_p && (data_rate_select || echo_shift_clock))
      for (int k = 0; k < 4; k++)
        cap[k] <= {cap[k][62:0], data_rate_select ? lane_p[k] : lane[k]};
    echo_p <= echo_shift_clock;
    lane_p <= lane;
  end
  // shift clock held still during the pulse
  task automatic strobe();
    @(posedge pclk);
    conversion_strobe_n <= 1'b1;
    repeat (4) @(posedge pclk);
    conversion_strobe_n <= 1'b0;
    for (int k = 0; k < 4; k++)
      cap[k] <= '0;
    repeat (8) @(posedge pclk);
  endtask : strobe
  task automatic shift(input int bits);
    int cycles;
    cycles = data_rate_select ? bits / 2 : bits;
    @(posedge pclk);
    repeat (cycles)
    begin
      shift_clock <= 1'b1;
      repeat (4) @(posedge pclk);
      shift_clock <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask : shift
endmodule : host_link

/* dv/quad_readout_tb.sv */
// self-checking bench of the quad readout block
`timescale 1ns/1ns
module quad_readout_tb;
  // ---------------------------------------------------------------------------
  // bench
  // ---------------------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, io_mode_diff, data_rate_select, dm, rm;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, rv;
  logic        pready, pslverr, e, strobe_n, sck, echo;
  logic [3:0]  cmos_lanes, diff_lanes;
  logic [15:0] r [4];
  int          mismatches, total_checks, nb;
  readout_pkg::power_state_t power_mode;

  always #5 pclk = ~pclk;

  quad_readout u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conversion_strobe_n(strobe_n), .shift_clock(sck), .io_mode_diff(io_mode_diff),
    .data_rate_select(data_rate_select), .cmos_lane_one(cmos_lanes[0]), .cmos_lane_two(cmos_lanes[1]),
    .cmos_lane_three(cmos_lanes[2]), .cmos_lane_four(cmos_lanes[3]), .diff_lane_a(diff_lanes[0]),
    .diff_lane_b(diff_lanes[1]), .diff_lane_c(diff_lanes[2]), .diff_lane_d(diff_lanes[3]),
    .echo_shift_clock(echo), .power_mode(power_mode));

  host_link u_host (.pclk(pclk), .io_mode_diff(io_mode_diff), .data_rate_select(data_rate_select),
    .cmos_lanes(cmos_lanes), .diff_lanes(diff_lanes), .echo_shift_clock(echo),
    .conversion_strobe_n(strobe_n), .shift_clock(sck));

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [63:0] exp_lane(int k, int n);
    logic [63:0] s;
    s = {r[k], r[(k + 1) % 4], r[(k + 2) % 4], r[(k + 3) % 4]};
    return s >> (64 - n);
  endfunction : exp_lane

  // after a readout in operation: state op, quiet count zero, readout active
  function automatic logic [63:0] exp_status(logic d, logic r);
    return (64'(r) << readout_pkg::ST_DDR_BIT) | (64'(d) << readout_pkg::ST_DIFF_BIT) |
           (64'h1 << readout_pkg::ST_READOUT_BIT);
  endfunction : exp_status

  task automatic pulses(input int n, input readout_pkg::power_state_t p);
    repeat (n) u_host.strobe();
    chk("power_mode", p, power_mode);
  endtask : pulses

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // generous bound: a full run needs well under half of it
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    summarize();
  end

  initial
  begin
    void'($urandom(75437));
    {presetn, psel, penable, pwrite, io_mode_diff, data_rate_select} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, readout_pkg::RESULT0_OFF, 32'h0000_0000);
    chk("result reset", 64'h0, q);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped error", 64'h1, e);
    apb(1'b1, readout_pkg::STATUS_OFF, 32'hFFFF_FFFF);
    chk("status write error", 64'h1, e);
    // every interface, rate and lane count: 16, 32 and 64 bits a lane
    for (int m = 0; m < 12; m++)
    begin
      dm = m[0];
      rm = m[1];
      nb = 16 << (m / 4);
      io_mode_diff <= dm;
      data_rate_select <= rm;
      for (int c = 0; c < 4; c++)
      begin
        rv = $urandom;
        apb(1'b1, 8'(c * 4), rv);
        r[c] = rv[15:0];
        apb(1'b0, 8'(c * 4), 32'h0000_0000);
        chk("result readback", {48'h0, rv[15:0]}, q);
      end
      u_host.strobe();
      for (int k = 0; k < 4; k++)
        chk("first msb", r[k][15], dm ? diff_lanes[k] : cmos_lanes[k]);
      chk("idle lanes", 64'h0, dm ? cmos_lanes : diff_lanes);
      u_host.shift(nb);
      for (int k = 0; k < 4; k++)
        chk("lane bits", exp_lane(k, nb), u_host.cap[k]);
      chk("stays awake", readout_pkg::PWR_OP, power_mode);
      apb(1'b0, readout_pkg::STATUS_OFF, 32'h0000_0000);
      chk("status", exp_status(dm, rm), q);
    end
    // sleep wakes come last: no readout ever relies on a reference that has not recharged
    for (int p = 0; p < 2; p++)
    begin
      dm = p[0];
      io_mode_diff <= dm;
      data_rate_select <= 1'b0;
      pulses(2, readout_pkg::PWR_NAP);
      u_host.shift(1);
      chk("nap wake", readout_pkg::PWR_OP, power_mode);
      pulses(2, readout_pkg::PWR_NAP);
      pulses(2, readout_pkg::PWR_SLEEP);
      u_host.shift(1);
      chk("shift in sleep", dm ? readout_pkg::PWR_SLEEP : readout_pkg::PWR_OP, power_mode);
      if (dm)
        pulses(1, readout_pkg::PWR_OP);
      pulses(2, readout_pkg::PWR_NAP);
      pulses(2, readout_pkg::PWR_SLEEP);
      pulses(1, readout_pkg::PWR_OP);
    end
    summarize();
  end
endmodule : quad_readout_tb
